// File: core/ssw_pkg.sv
// Shared constants for the synchronous serial word framing block.
package ssw_pkg;
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned BUF_DEPTH  = 2;
  localparam int unsigned CFG_W      = 9;
  localparam int unsigned LVL_W      = 2;
  localparam int unsigned CNT_W      = 4;

  // Word length selector codes, format bit is the upper bit.
  localparam logic [1:0] FMT_16 = 2'h0;
  localparam logic [1:0] FMT_10 = 2'h1;
  localparam logic [1:0] FMT_8  = 2'h2;
  localparam logic [1:0] FMT_12 = 2'h3;

  // Index of the first bit on the wire for each word length.
  localparam logic [3:0] MSB_16 = 4'hF;
  localparam logic [3:0] MSB_10 = 4'h9;
  localparam logic [3:0] MSB_8  = 4'h7;
  localparam logic [3:0] MSB_12 = 4'hB;

  // Field positions inside the synchronised configuration vector.
  localparam int unsigned CFG_FMT_LO = 0;
  localparam int unsigned CFG_MODE   = 2;
  localparam int unsigned CFG_IGN    = 3;
  localparam int unsigned CFG_POL    = 4;
  localparam int unsigned CFG_FSEXT  = 5;
  localparam int unsigned CFG_STOP   = 6;
  localparam int unsigned CFG_SOFT   = 7;
  localparam int unsigned CFG_RUN    = 8;

  localparam logic [CFG_W-1:0] CFG_RESET = 9'h000;
  localparam logic [LVL_W-1:0] LVL_RESET = 2'h0;
endpackage

// File: core/ssw_sync2.sv
// Two-flop level synchroniser.
`timescale 1ns/1ps
module ssw_sync2
(
  input  wire logic clk,
  input  wire logic d,
  output logic      q
);
  logic meta_q;

  // The first stage is read only by the second stage.
  always_ff @(posedge clk)
  begin
    meta_q <= d;
    q      <= meta_q;
  end
endmodule

// File: core/ssw_fifo.sv
// Parameterised flip-flop FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module ssw_fifo
#(
  parameter int unsigned W     = 16,
  parameter int unsigned DEPTH = 4,
  parameter int unsigned CW    = $clog2(DEPTH + 1)
)
(
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic [W-1:0]  in_data,
  input  wire logic          in_valid,
  output logic               in_ready,
  output logic [W-1:0]       out_data,
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic [CW-1:0]      count
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_q != CW'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign count     = cnt_q;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= (wr_q == LAST) ? '0 : wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= (rd_q == LAST) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + CW'(push) - CW'(pop);
    end
  end
endmodule

// File: core/ssw_top.sv
// Serial word port: FIFOs, word format, frame sync and shifters.
`timescale 1ns/1ps
module ssw_top
  import ssw_pkg::*;
(
  input  wire logic                        core_clk,
  input  wire logic                        rst_n,
  input  wire logic                        link_clk,
  input  wire logic                        word_format_bit,
  input  wire logic                        format_extension_bit,
  input  wire logic                        frame_sync_mode_bit,
  input  wire logic                        frame_ignore_bit,
  input  wire logic                        frame_sync_polarity_bit,
  input  wire logic                        tx_fs_external,
  input  wire logic                        free_run_bit,
  input  wire logic                        soft_stop_bit,
  input  wire logic                        debug_halt,
  input  wire logic [ssw_pkg::LVL_W-1:0]   rx_fifo_irq_level,
  input  wire logic [ssw_pkg::LVL_W-1:0]   tx_fifo_irq_level,
  input  wire logic [ssw_pkg::WORD_W-1:0]  tx_data,
  input  wire logic                        tx_valid,
  output logic                             tx_ready,
  output logic [ssw_pkg::WORD_W-1:0]       rd_data,
  output logic                             rd_valid,
  input  wire logic                        rd_ready,
  output logic                             rx_irq,
  output logic                             tx_irq,
  output logic                             serial_dx,
  input  wire logic                        serial_dr,
  input  wire logic                        tx_frame_sync_pin_in,
  output logic                             tx_frame_sync_pin_out,
  output logic                             tx_frame_sync_pin_oe_n,
  input  wire logic                        rx_frame_sync_pin
);
  localparam int unsigned FCW = $clog2(FIFO_DEPTH + 1);
  localparam int unsigned BCW = $clog2(BUF_DEPTH + 1);

  typedef enum logic [1:0] {TX_IDLE, TX_FS, TX_SHIFT} ssw_tx_st_t;
  typedef enum logic [0:0] {RX_IDLE, RX_SHIFT} ssw_rx_st_t;

  // ---------------- Core clock domain ----------------
  logic [CFG_W-1:0]  cfg_q;
  logic [LVL_W-1:0]  rx_lvl_q;
  logic [LVL_W-1:0]  tx_lvl_q;
  logic [WORD_W-1:0] txf_data;
  logic              txf_valid;
  logic              txf_ready;
  logic [FCW-1:0]    txf_cnt;
  logic [FCW-1:0]    rxf_cnt;
  logic              rxf_in_ready;
  logic [WORD_W-1:0] rxf_data;
  logic              rxf_valid;
  logic              rxf_ready;
  logic [WORD_W-1:0] tx_hold_q;
  logic              tx_req_q;
  logic              tx_ack_s;
  logic              rx_req_s;
  logic              rx_ack_q;
  logic              rx_new;
  logic [WORD_W-1:0] rx_word_q;

  // Option bits are captured so that they read as zero after reset.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cfg_q    <= CFG_RESET;
      rx_lvl_q <= LVL_RESET;
      tx_lvl_q <= LVL_RESET;
    end
    else
    begin
      cfg_q <= {free_run_bit, soft_stop_bit,
                debug_halt && !free_run_bit && !soft_stop_bit,
                tx_fs_external, frame_sync_polarity_bit,
                frame_ignore_bit, frame_sync_mode_bit,
                word_format_bit, format_extension_bit};
      rx_lvl_q <= rx_fifo_irq_level;
      tx_lvl_q <= tx_fifo_irq_level;
    end
  end

  ssw_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo
  (
    .clk       (core_clk),
    .rst_n     (rst_n),
    .in_data   (tx_data),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (txf_data),
    .out_valid (txf_valid),
    .out_ready (txf_ready),
    .count     (txf_cnt)
  );

  // A new word is handed over only once the link acknowledged the last.
  assign txf_ready = (tx_req_q == tx_ack_s);

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      tx_req_q  <= 1'b0;
      tx_hold_q <= '0;
    end
    else if (txf_valid && txf_ready)
    begin
      tx_hold_q <= txf_data;
      tx_req_q  <= !tx_req_q;
    end
  end

  // The link word is held until the receive FIFO takes it.
  assign rx_new = (rx_req_s != rx_ack_q);

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      rx_ack_q <= 1'b0;
    end
    else if (rx_new && rxf_in_ready)
    begin
      rx_ack_q <= !rx_ack_q;
    end
  end

  ssw_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo
  (
    .clk       (core_clk),
    .rst_n     (rst_n),
    .in_data   (rx_word_q),
    .in_valid  (rx_new),
    .in_ready  (rxf_in_ready),
    .out_data  (rxf_data),
    .out_valid (rxf_valid),
    .out_ready (rxf_ready),
    .count     (rxf_cnt)
  );

  // Output skid buffer: holds two more words for a stalled reader.
  ssw_fifo #(.W(WORD_W), .DEPTH(BUF_DEPTH)) u_rd_buf
  (
    .clk       (core_clk),
    .rst_n     (rst_n),
    .in_data   (rxf_data),
    .in_valid  (rxf_valid),
    .in_ready  (rxf_ready),
    .out_data  (rd_data),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .count     ()
  );

  // Level 0..3 asks for more than that many receive words present.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      rx_irq <= 1'b0;
      tx_irq <= 1'b0;
    end
    else
    begin
      rx_irq <= (rxf_cnt > FCW'(rx_lvl_q));
      tx_irq <= (txf_cnt <= FCW'(tx_lvl_q));
    end
  end

  // ---------------- Link clock domain ----------------
  logic              lrst_a;
  logic              lrst_s;
  logic              debug_halt_l;
  logic [CFG_W-1:0]  lcfg;
  logic              tx_req_s;
  logic              tx_ack_q;
  logic              rx_req_q;
  logic              rx_ack_s;
  logic [WORD_W-1:0] tx_sr_q;
  logic [WORD_W-1:0] rx_sr_q;
  logic [CNT_W-1:0]  tx_cnt_q;
  logic [CNT_W-1:0]  rx_cnt_q;
  ssw_tx_st_t        tx_st_q;
  ssw_rx_st_t        rx_st_q;
  logic [3:0]        msb;
  logic              cont;
  logic              stop_now;
  logic              no_start;
  logic              tx_fs_act;
  logic              rx_fs_act;
  logic              tx_have;
  logic [WORD_W-1:0] rx_full;
  logic [WORD_W-1:0] rx_ext;

  // Two extra stages hold the link in reset until the options have
  // crossed, so the shifters never run on reset option values.
  ssw_sync2 u_rst_sync (.clk(link_clk), .d(rst_n), .q(lrst_a));
  ssw_sync2 u_rst_hold (.clk(link_clk), .d(lrst_a), .q(lrst_s));
  ssw_sync2 u_treq_sync (.clk(link_clk), .d(tx_req_q), .q(tx_req_s));
  ssw_sync2 u_rack_sync (.clk(link_clk), .d(rx_ack_q), .q(rx_ack_s));
  ssw_sync2 u_tack_sync (.clk(core_clk), .d(tx_ack_q), .q(tx_ack_s));
  ssw_sync2 u_rreq_sync (.clk(core_clk), .d(rx_req_q), .q(rx_req_s));

  for (genvar i = 0; i < CFG_W; i++)
  begin : g_cfg_sync
    ssw_sync2 u_sync (.clk(link_clk), .d(cfg_q[i]), .q(lcfg[i]));
  end

  always_comb
  begin
    unique case (lcfg[CFG_FMT_LO +: 2])
      FMT_16: msb = MSB_16;
      FMT_10: msb = MSB_10;
      FMT_8:  msb = MSB_8;
      FMT_12: msb = MSB_12;
    endcase
  end

  assign cont      = !lcfg[CFG_MODE];
  assign tx_fs_act = tx_frame_sync_pin_in ^ lcfg[CFG_POL];
  assign rx_fs_act = rx_frame_sync_pin ^ lcfg[CFG_POL];
  // Immediate stop freezes mid-word; soft stop only refuses new words.
  assign stop_now  = lcfg[CFG_STOP];
  assign no_start  = lcfg[CFG_SOFT] && !lcfg[CFG_RUN] && debug_halt_l;
  assign tx_have   = (tx_req_s != tx_ack_q);

  ssw_sync2 u_halt_sync (.clk(link_clk), .d(debug_halt), .q(debug_halt_l));

  // Transmit shifter.
  always_ff @(posedge link_clk)
  begin
    if (!lrst_s)
    begin
      tx_st_q                <= TX_IDLE;
      tx_sr_q                <= '0;
      tx_cnt_q               <= '0;
      tx_ack_q               <= 1'b0;
      serial_dx              <= 1'b0;
      tx_frame_sync_pin_out  <= 1'b0;
      tx_frame_sync_pin_oe_n <= 1'b1;
    end
    else if (!stop_now)
    begin
      tx_frame_sync_pin_oe_n <= lcfg[CFG_FSEXT];
      tx_frame_sync_pin_out  <= lcfg[CFG_POL];
      unique case (tx_st_q)
        TX_IDLE:
        begin
          if (tx_have && !no_start)
          begin
            if (!lcfg[CFG_FSEXT])
            begin
              tx_st_q               <= TX_FS;
              tx_frame_sync_pin_out <= !lcfg[CFG_POL];
            end
            else if (tx_fs_act)
            begin
              tx_st_q   <= TX_SHIFT;
              tx_sr_q   <= tx_hold_q;
              serial_dx <= tx_hold_q[msb];
              tx_cnt_q  <= msb;
              tx_ack_q  <= !tx_ack_q;
            end
          end
        end
        TX_FS:
        begin
          tx_st_q   <= TX_SHIFT;
          tx_sr_q   <= tx_hold_q;
          serial_dx <= tx_hold_q[msb];
          tx_cnt_q  <= msb;
          tx_ack_q  <= !tx_ack_q;
        end
        TX_SHIFT:
        begin
          if (cont && lcfg[CFG_FSEXT] && tx_fs_act && !lcfg[CFG_IGN])
          begin
            tx_cnt_q  <= msb;
            serial_dx <= tx_sr_q[msb];
          end
          else if (tx_cnt_q != '0)
          begin
            tx_cnt_q  <= tx_cnt_q - 1'b1;
            serial_dx <= tx_sr_q[tx_cnt_q - 1'b1];
          end
          else if (cont && tx_have && !no_start)
          begin
            tx_sr_q   <= tx_hold_q;
            serial_dx <= tx_hold_q[msb];
            tx_cnt_q  <= msb;
            tx_ack_q  <= !tx_ack_q;
          end
          else
          begin
            tx_st_q <= TX_IDLE;
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  // Receive shifter; sign extension follows the word length.
  assign rx_full = {rx_sr_q[WORD_W-2:0], serial_dr};

  always_comb
  begin
    unique case (lcfg[CFG_FMT_LO +: 2])
      FMT_16: rx_ext = rx_full;
      FMT_10: rx_ext = {{6{rx_full[9]}}, rx_full[9:0]};
      FMT_8:  rx_ext = {{8{rx_full[7]}}, rx_full[7:0]};
      FMT_12: rx_ext = {{4{rx_full[11]}}, rx_full[11:0]};
    endcase
  end

  always_ff @(posedge link_clk)
  begin
    if (!lrst_s)
    begin
      rx_st_q   <= RX_IDLE;
      rx_sr_q   <= '0;
      rx_cnt_q  <= '0;
      rx_word_q <= '0;
      rx_req_q  <= 1'b0;
    end
    else if (!stop_now)
    begin
      unique case (rx_st_q)
        RX_IDLE:
        begin
          if (rx_fs_act && !no_start)
          begin
            rx_st_q  <= RX_SHIFT;
            rx_cnt_q <= msb;
          end
        end
        RX_SHIFT:
        begin
          if (cont && rx_fs_act && !lcfg[CFG_IGN])
          begin
            rx_cnt_q <= msb;
          end
          else
          begin
            rx_sr_q <= rx_full;
            if (rx_cnt_q != '0)
            begin
              rx_cnt_q <= rx_cnt_q - 1'b1;
            end
            else
            begin
              // A word finished before the core took the last is dropped.
              if (rx_req_q == rx_ack_s)
              begin
                rx_word_q <= rx_ext;
                rx_req_q  <= !rx_req_q;
              end
              rx_cnt_q <= msb;
              if (!cont || no_start)
              begin
                rx_st_q <= RX_IDLE;
              end
            end
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // ---------------- Assertions ----------------
  sequence s_tx_load;
    (tx_st_q == TX_FS) && !stop_now;
  endsequence

  property p_len_load;
    @(posedge link_clk) disable iff (!lrst_s)
      s_tx_load |=> (tx_cnt_q == $past(msb));
  endproperty
  a_len_load: assert property (p_len_load)
    else $error("Word length count wrong at load.");

  property p_msb_first;
    @(posedge link_clk) disable iff (!lrst_s)
      s_tx_load |=> (serial_dx == $past(tx_hold_q[msb]));
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("First bit is not the top bit.");

  property p_sign_ext;
    @(posedge link_clk) disable iff (!lrst_s)
      ($changed(rx_req_q) && lcfg[CFG_FMT_LO +: 2] == FMT_8)
        |-> (rx_word_q[15:8] == {8{rx_word_q[7]}});
  endproperty
  a_sign_ext: assert property (p_sign_ext)
    else $error("Short receive word not sign extended.");

  property p_reset_zero;
    @(posedge core_clk) !rst_n |=> (cfg_q == CFG_RESET);
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("Option bits not zero after reset.");

  property p_wait_fs;
    @(posedge link_clk) disable iff (!lrst_s)
      (rx_st_q == RX_IDLE && !rx_fs_act) |=> (rx_st_q == RX_IDLE);
  endproperty
  a_wait_fs: assert property (p_wait_fs)
    else $error("Receive started without frame sync.");

  property p_ignore;
    @(posedge link_clk) disable iff (!lrst_s)
      (rx_st_q == RX_SHIFT && cont && lcfg[CFG_IGN] && !stop_now
       && rx_cnt_q != '0) |=> (rx_cnt_q == $past(rx_cnt_q) - 1'b1);
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("Ignored frame sync restarted the word.");

  property p_fs_drive;
    @(posedge link_clk) disable iff (!lrst_s)
      s_tx_load |-> (tx_frame_sync_pin_out != lcfg[CFG_POL]);
  endproperty
  a_fs_drive: assert property (p_fs_drive)
    else $error("Driven frame sync has wrong level.");

  property p_full_block;
    @(posedge core_clk) disable iff (!rst_n)
      (txf_cnt == FCW'(FIFO_DEPTH)) |-> !tx_ready;
  endproperty
  a_full_block: assert property (p_full_block)
    else $error("Full transmit FIFO accepted a write.");

  property p_rx_irq;
    @(posedge core_clk) disable iff (!rst_n)
      ##1 (rx_irq == $past(rxf_cnt > FCW'(rx_lvl_q)));
  endproperty
  a_rx_irq: assert property (p_rx_irq)
    else $error("Receive interrupt does not follow level.");

  property p_halt;
    @(posedge link_clk) disable iff (!lrst_s)
      stop_now |=> ($stable(tx_cnt_q) && $stable(rx_cnt_q));
  endproperty
  a_halt: assert property (p_halt)
    else $error("Port moved during hard debug halt.");
endmodule

// File: tb/ssw_codec_model.sv
// Behavioural codec that loops data back and watches the transmit wire.
`timescale 1ns/1ps
module ssw_codec_model
(
  input  wire logic        link_clk,
  input  wire logic [1:0]  fmt,
  input  wire logic        pol,
  input  wire logic        cont,
  input  wire logic        ign,
  input  wire logic        ext_go,
  input  wire logic        serial_dx,
  input  wire logic        fs_out,
  input  wire logic        fs_oe_n,
  output logic             fs_pin,
  output logic             serial_dr,
  output logic [15:0]      word_q
);
  logic [15:0] sr_q;
  logic [4:0]  cnt_q;
  logic        go_q;
  logic        fs_in;
  logic [4:0]  len;
  logic [15:0] mask;
  initial
  begin
    cnt_q = 5'h00;
    go_q = 1'b0;
    fs_in = 1'b0;
  end
  always_comb
  begin
    case (fmt)
      2'h0: len = 5'h10;
      2'h1: len = 5'h0A;
      2'h2: len = 5'h08;
      default: len = 5'h0C;
    endcase
  end
  assign mask = 16'hFFFF >> (5'h10 - len);
  // The shared pin follows whichever side has it enabled.
  assign fs_pin = fs_oe_n ? fs_in : fs_out;
  // Wire loopback so every sent word comes straight back in.
  assign serial_dr = serial_dx;
  always @(posedge link_clk)
  begin
    go_q <= ext_go;
    fs_in <= (ext_go && !go_q) ? ~pol : pol;
    if (fs_pin == ~pol && (cnt_q == 5'h00 || !ign))
    begin
      cnt_q <= len;
      sr_q <= 16'h0000;
    end
    else if (cnt_q != 5'h00)
    begin
      sr_q <= {sr_q[14:0], serial_dx};
      cnt_q <= (cnt_q == 5'h01 && cont) ? len : cnt_q - 5'h01;
      if (cnt_q == 5'h01)
      begin
        word_q <= {sr_q[14:0], serial_dx} & mask;
      end
    end
  end
endmodule

// File: tb/test_sync_serial_word_framing.sv
// Self-checking bench for the serial word framing port.
`timescale 1ns/1ps
module test_sync_serial_word_framing;
  import ssw_pkg::*;
  localparam logic [15:0] MSK [4] = '{16'hFFFF, 16'h03FF, 16'h00FF, 16'h0FFF};
  localparam logic [15:0] PAT [2] = '{16'hB6D9, 16'h4926};
  logic        core_clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        word_format_bit = 1'b0;
  logic        format_extension_bit = 1'b0;
  logic        frame_sync_mode_bit = 1'b0;
  logic        frame_ignore_bit = 1'b0;
  logic        frame_sync_polarity_bit = 1'b0;
  logic        tx_fs_external = 1'b0;
  logic        free_run_bit = 1'b0;
  logic        soft_stop_bit = 1'b0;
  logic        debug_halt = 1'b0;
  logic [1:0]  rx_fifo_irq_level = 2'h0;
  logic [1:0]  tx_fifo_irq_level = 2'h0;
  logic [15:0] tx_data = 16'h0000;
  logic        tx_valid = 1'b0;
  logic        rd_ready = 1'b0;
  logic        ext_go = 1'b0;
  logic        tx_ready, rd_valid, rx_irq, tx_irq, serial_dx, serial_dr;
  logic        fs_pin, fs_out, fs_oe_n, ok;
  logic [15:0] rd_data, word_q, w;
  int          mismatches = 0;
  int          checks = 0;
  int          cycles = 0;
  int          acc;

  ssw_top dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .link_clk(link_clk),
    .word_format_bit(word_format_bit),
    .format_extension_bit(format_extension_bit),
    .frame_sync_mode_bit(frame_sync_mode_bit),
    .frame_ignore_bit(frame_ignore_bit),
    .frame_sync_polarity_bit(frame_sync_polarity_bit),
    .tx_fs_external(tx_fs_external), .free_run_bit(free_run_bit),
    .soft_stop_bit(soft_stop_bit), .debug_halt(debug_halt),
    .rx_fifo_irq_level(rx_fifo_irq_level),
    .tx_fifo_irq_level(tx_fifo_irq_level),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rx_irq(rx_irq), .tx_irq(tx_irq),
    .serial_dx(serial_dx), .serial_dr(serial_dr),
    .tx_frame_sync_pin_in(fs_pin), .tx_frame_sync_pin_out(fs_out),
    .tx_frame_sync_pin_oe_n(fs_oe_n), .rx_frame_sync_pin(fs_pin)
  );

  ssw_codec_model codec_u (
    .link_clk(link_clk),
    .fmt({word_format_bit, format_extension_bit}),
    .pol(frame_sync_polarity_bit), .cont(!frame_sync_mode_bit),
    .ign(frame_ignore_bit), .ext_go(ext_go), .serial_dx(serial_dx),
    .fs_out(fs_out), .fs_oe_n(fs_oe_n), .fs_pin(fs_pin),
    .serial_dr(serial_dr), .word_q(word_q)
  );

  always #4 core_clk = ~core_clk;
  always #15 link_clk = ~link_clk;

  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // A hung handshake ends the run here rather than stalling forever.
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      mismatches++;
      results();
    end
  end

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [15:0] sext(logic [15:0] v, logic [1:0] f);
    case (f)
      2'h1: return {{6{v[9]}}, v[9:0]};
      2'h2: return {{8{v[7]}}, v[7:0]};
      2'h3: return {{4{v[11]}}, v[11:0]};
      default: return v;
    endcase
  endfunction

  task automatic try_put(input logic [15:0] v, output logic taken);
    @(posedge core_clk);
    tx_data <= v;
    tx_valid <= 1'b1;
    @(negedge core_clk);
    taken = tx_ready;
    @(posedge core_clk);
    tx_valid <= 1'b0;
  endtask

  // The write stands until the port is seen ready at a falling edge.
  task automatic put(input logic [15:0] v);
    @(posedge core_clk);
    tx_data <= v;
    tx_valid <= 1'b1;
    do @(negedge core_clk); while (tx_ready !== 1'b1);
    @(posedge core_clk);
    tx_valid <= 1'b0;
  endtask

  task automatic get(input logic [15:0] exp);
    do @(negedge core_clk); while (rd_valid !== 1'b1);
    check("rd_data", rd_data, exp);
    @(posedge core_clk) rd_ready <= 1'b1;
    @(posedge core_clk) rd_ready <= 1'b0;
  endtask

  // Reset also stops a receiver left running in continuous mode, and
  // the drain clears any stray word caught while the pin level moved.
  task automatic restart();
    @(posedge core_clk) rst_n <= 1'b0;
    repeat (8) @(posedge link_clk);
    @(posedge core_clk) rst_n <= 1'b1;
    repeat (60) @(posedge core_clk);
    rd_ready <= 1'b1;
    repeat (300) @(posedge core_clk);
    rd_ready <= 1'b0;
  endtask

  initial
  begin
    repeat (24) @(posedge core_clk);
    check("rx_irq", rx_irq, 16'h0000);
    check("fs enable", fs_oe_n, 16'h0001);
    check("rd_valid", rd_valid, 16'h0000);
    frame_sync_mode_bit <= 1'b1;
    for (int p = 0; p < 2; p++)
    begin
      frame_sync_polarity_bit <= p[0];
      restart();
      check("tx_irq", tx_irq, 16'h0001);
      for (int f = 0; f < 4; f++)
      begin
        word_format_bit <= f[1];
        format_extension_bit <= f[0];
        repeat (20) @(posedge core_clk);
        for (int k = 0; k < 2; k++)
        begin
          w = PAT[k] & MSK[f];
          put(w);
          get(sext(w, f[1:0]));
          check("wire word", word_q, w);
        end
      end
    end
    $display("test formats done");
    frame_sync_mode_bit <= 1'b0;
    word_format_bit <= 1'b0;
    format_extension_bit <= 1'b1;
    restart();
    for (int k = 0; k < 3; k++) put(16'h0301 + k[15:0]);
    for (int k = 0; k < 3; k++) get(16'hFF01 + k[15:0]);
    $display("test continuous done");
    frame_sync_mode_bit <= 1'b1;
    rx_fifo_irq_level <= 2'h3;
    restart();
    for (int k = 0; k < 8; k++) put(16'h0040 + k[15:0]);
    repeat (400) @(posedge core_clk);
    check("rx_irq full", rx_irq, 16'h0001);
    for (int k = 0; k < 6; k++) get(16'h0040 + k[15:0]);
    check("rx_irq drained", rx_irq, 16'h0000);
    $display("test receive overrun done");
    tx_fs_external <= 1'b1;
    frame_sync_mode_bit <= 1'b0;
    frame_ignore_bit <= 1'b1;
    restart();
    acc = 0;
    for (int k = 0; k < 8; k++)
    begin
      try_put(16'h0123 + k[15:0], ok);
      acc += int'(ok);
    end
    check("tx accepted", 16'(acc >= 4 && acc <= 6), 16'h0001);
    check("tx_ready", tx_ready, 16'h0000);
    check("tx_irq full", tx_irq, 16'h0000);
    ext_go <= 1'b1;
    get(16'h0123);
    ext_go <= 1'b0;
    repeat (40) @(posedge core_clk);
    ext_go <= 1'b1;
    for (int k = 1; k < acc; k++) get(16'h0123 + k[15:0]);
    ext_go <= 1'b0;
    $display("test transmit full done");
    tx_fs_external <= 1'b0;
    frame_sync_mode_bit <= 1'b1;
    debug_halt <= 1'b1;
    restart();
    put(16'h0077);
    repeat (400) @(posedge core_clk);
    check("halted", rd_valid, 16'h0000);
    soft_stop_bit <= 1'b1;
    repeat (400) @(posedge core_clk);
    check("soft halted", rd_valid, 16'h0000);
    free_run_bit <= 1'b1;
    get(16'h0077);
    $display("test debug halt done");
    results();
  end
endmodule
